// ---- tsw_pkg.sv ----
// shared constants and a map check for the touch-sensor communication-window link
package tsw_pkg;
  localparam int unsigned SYS_CLK_HZ      = 20_000_000;
  localparam int unsigned LINK_CLK_HZ     = 8_000_000;
  localparam int unsigned FORCE_LOW_MS    = 10;
  localparam int unsigned STARTUP_MS      = 15;
  localparam int unsigned SETUP_TMO_MS    = 22;
  // cycle counts; every time is ms times whole cycles per ms, with no rounding up
  localparam int unsigned FORCE_LOW_CYC   = (FORCE_LOW_MS * (SYS_CLK_HZ / 1000));
  localparam int unsigned STARTUP_CYC     = (STARTUP_MS * (LINK_CLK_HZ / 1000));
  localparam int unsigned SETUP_TMO_CYC   = (SETUP_TMO_MS * (LINK_CLK_HZ / 1000));
  // forced-window detector: line low for more than this many link cycles counts as a force
  localparam int unsigned FORCE_DET_CYC   = 1024;
  localparam logic [6:0]  DEV_ADDR        = 7'h44;
  // register map: main block, long-term-average block, gap, settings block
  localparam logic [7:0]  MAP_LTA_LAST    = 8'h3F;
  localparam logic [7:0]  MAP_SET_FIRST   = 8'h80;
  localparam logic [7:0]  MAP_SET_LAST    = 8'h9F;
  localparam int unsigned SCL_HALF_CYC    = 25;
  localparam int unsigned POLL_LIMIT      = 8;
  localparam logic [7:0]  RESET_PTR       = 8'h00;

  // true for addresses that exist in the map (gap is not skipped)
  function automatic logic tsw_in_map(input logic [7:0] a);
    return (a <= MAP_LTA_LAST) || ((a >= MAP_SET_FIRST) && (a <= MAP_SET_LAST));
  endfunction
endpackage

// ---- tsw_if.sv ----
// two-wire bus plus window-ready line between the bus master and the device
`timescale 1ns/1ns
interface tsw_if;
  logic scl_o_m;
  logic scl_oe_m;
  logic sda_o_m;
  logic sda_oe_m;
  logic rdy_o_m;
  logic rdy_oe_m;
  logic scl_o_d;
  logic scl_oe_d;
  logic sda_o_d;
  logic sda_oe_d;
  logic rdy_o_d;
  logic rdy_oe_d;
  logic scl;
  logic sda;
  logic rdy;
  // open-drain wired-and with pull-ups
  assign scl = ~((scl_oe_m & ~scl_o_m) | (scl_oe_d & ~scl_o_d));
  assign sda = ~((sda_oe_m & ~sda_o_m) | (sda_oe_d & ~sda_o_d));
  assign rdy = ~((rdy_oe_m & ~rdy_o_m) | (rdy_oe_d & ~rdy_o_d));
  modport master (output scl_o_m, scl_oe_m, sda_o_m, sda_oe_m, rdy_o_m, rdy_oe_m,
                  input scl, sda, rdy);
  modport device (output scl_o_d, scl_oe_d, sda_o_d, sda_oe_d, rdy_o_d, rdy_oe_d,
                  input scl, sda, rdy);
endinterface

// ---- tsw_device.sv ----
// device end: communication window, ready line and write-only slave on the link clock
`timescale 1ns/1ns
module tsw_device
  import tsw_pkg::*;
#(
  parameter int unsigned STARTUP_CYCLES = STARTUP_CYC,
  parameter int unsigned SETUP_TMO      = SETUP_TMO_CYC
)(
  // link side
  input  wire logic       link_clk,
  input  wire logic       rst_b,
  tsw_if.device           bus,
  // conversion engine side
  input  wire logic       conv_done,
  input  wire logic       stretch_req,
  output logic            conv_start,
  output logic            wr_stb,
  output logic [7:0]      wr_addr,
  output logic [7:0]      wr_data,
  output logic            in_window
);
  typedef enum logic [3:0] {
    WS_BOOT  = 4'b0001,
    WS_SETUP = 4'b0010,
    WS_CONV  = 4'b0100,
    WS_OPEN  = 4'b1000
  } tsw_win_t;
  typedef enum logic [4:0] {
    BS_IDLE = 5'b00001,
    BS_CTRL = 5'b00010,
    BS_ADDR = 5'b00100,
    BS_DATA = 5'b01000,
    BS_SKIP = 5'b10000
  } tsw_bus_t;

  tsw_win_t   win_r;
  tsw_bus_t   bst_r;
  logic [1:0] scl_s_r;
  logic [1:0] sda_s_r;
  logic [1:0] rdy_s_r;
  logic       scl_q_r;
  logic       sda_q_r;
  logic [3:0] bit_r;
  logic [7:0] shf_r;
  logic       ack_r;
  logic       serviced_r;
  logic [7:0] ptr_r;
  logic [23:0] cnt_r;
  logic [10:0] frc_r;
  logic       forced_r;
  logic       hold_r;
  logic       start_ev;
  logic       stop_ev;
  logic       scl_rise;
  logic       scl_fall;
  logic       byte_done;

  // bus pins come from the far side, so two flops before use
  always_ff @(posedge link_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      scl_s_r <= 2'h3;
      sda_s_r <= 2'h3;
      rdy_s_r <= 2'h3;
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
      hold_r  <= 1'b0;
    end
    else
    begin
      scl_s_r <= {scl_s_r[0], bus.scl};
      sda_s_r <= {sda_s_r[0], bus.sda};
      rdy_s_r <= {rdy_s_r[0], bus.rdy};
      scl_q_r <= scl_s_r[1];
      sda_q_r <= sda_s_r[1];
      hold_r  <= bus.scl_oe_d;
    end
  end

  // line events from synchronised samples only
  assign start_ev  = scl_s_r[1] & scl_q_r & sda_q_r & ~sda_s_r[1];
  assign stop_ev   = scl_s_r[1] & scl_q_r & ~sda_q_r & sda_s_r[1];
  assign scl_rise  = scl_s_r[1] & ~scl_q_r;
  assign scl_fall  = ~scl_s_r[1] & scl_q_r;
  assign byte_done = scl_rise & (bit_r == 4'h7);

  // external low on ready while we are not driving it is a forcing handshake
  always_ff @(posedge link_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      frc_r    <= 11'h000;
      forced_r <= 1'b0;
    end
    else if (win_r == WS_OPEN || win_r == WS_SETUP)
    begin
      frc_r    <= 11'h000;
      forced_r <= 1'b0;
    end
    else if (!rdy_s_r[1])
    begin
      if (frc_r != 11'(FORCE_DET_CYC))
        frc_r <= frc_r + 11'h001;
      else
        forced_r <= 1'b1;
    end
    else
      frc_r <= 11'h000;
  end

  // window state machine
  always_ff @(posedge link_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      win_r <= WS_BOOT;
      cnt_r <= 24'h000000;
    end
    else
    begin
      case (win_r)
        WS_BOOT:
        begin
          cnt_r <= cnt_r + 24'h000001;
          if (cnt_r == 24'(STARTUP_CYCLES - 1))
          begin
            win_r <= WS_SETUP;
            cnt_r <= 24'h000000;
          end
        end
        WS_SETUP:
        begin
          cnt_r <= cnt_r + 24'h000001;
          if (stop_ev && serviced_r)
            win_r <= WS_CONV;
          else if (!serviced_r && cnt_r == 24'(SETUP_TMO - 1))
            win_r <= WS_CONV;
        end
        WS_CONV:
          if (conv_done || forced_r)
            win_r <= WS_OPEN;
        WS_OPEN:
          if (stop_ev)
            win_r <= WS_CONV;
        default:
          win_r <= WS_BOOT;
      endcase
    end
  end

  assign in_window  = (win_r == WS_OPEN) || (win_r == WS_SETUP);
  // one-cycle request to run the next conversion when a stop closes the window
  assign conv_start = in_window && stop_ev && (win_r == WS_OPEN || serviced_r);

  // byte receiver, pointer and acknowledge
  always_ff @(posedge link_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      bst_r      <= BS_IDLE;
      bit_r      <= 4'h0;
      shf_r      <= 8'h00;
      ack_r      <= 1'b0;
      ptr_r      <= RESET_PTR;
      serviced_r <= 1'b0;
      wr_stb     <= 1'b0;
      wr_addr    <= 8'h00;
      wr_data    <= 8'h00;
    end
    else
    begin
      wr_stb <= 1'b0;
      if (win_r == WS_CONV)
        serviced_r <= 1'b0;
      if (start_ev)
      begin
        bst_r <= BS_CTRL;              // repeated start restarts at the control byte
        bit_r <= 4'h0;
        ack_r <= 1'b0;
      end
      else if (stop_ev)
      begin
        bst_r <= BS_IDLE;
        ack_r <= 1'b0;
      end
      else if (bst_r != BS_IDLE)
      begin
        if (scl_rise && bit_r < 4'h8)
        begin
          shf_r <= {shf_r[6:0], sda_s_r[1]};
          bit_r <= bit_r + 4'h1;
        end
        if (byte_done)
        begin
          case (bst_r)
            BS_CTRL:
              // no side effect when addressed outside the window
              if ({shf_r[6:0], sda_s_r[1]} == {DEV_ADDR, 1'b0} && in_window)
              begin
                ack_r      <= 1'b1;
                serviced_r <= 1'b1;
                bst_r      <= BS_ADDR;
              end
              else
                bst_r <= BS_SKIP;
            BS_ADDR:
            begin
              ptr_r <= {shf_r[6:0], sda_s_r[1]};
              ack_r <= 1'b1;
              bst_r <= BS_DATA;
            end
            BS_DATA:
            begin
              if (tsw_in_map(ptr_r))
              begin
                wr_stb  <= 1'b1;
                wr_addr <= ptr_r;
                wr_data <= {shf_r[6:0], sda_s_r[1]};
              end
              ptr_r <= ptr_r + 8'h01;
              ack_r <= 1'b1;
            end
            default:
              bst_r <= BS_SKIP;
          endcase
        end
        // ack slot ends on falling edge after the ninth clock
        if (scl_fall && bit_r == 4'h9)
        begin
          bit_r <= 4'h0;
          ack_r <= 1'b0;
        end
        else if (scl_rise && bit_r == 4'h8)
          bit_r <= 4'h9;
      end
    end
  end

  // drive sda low only after the eighth falling edge while acking
  assign bus.sda_o_d  = 1'b0;
  assign bus.sda_oe_d = ack_r && in_window && (bit_r >= 4'h8) && !(bit_r == 4'h8 && scl_q_r);
  // stretch starts only as scl is seen falling; a later start could cut a released high phase
  assign bus.scl_o_d  = 1'b0;
  assign bus.scl_oe_d = stretch_req && in_window && (bst_r != BS_IDLE) && (scl_fall || hold_r);
  // ready low exactly while the window is open, used or not
  assign bus.rdy_o_d  = 1'b0;
  assign bus.rdy_oe_d = in_window;
endmodule

// ---- tsw_master.sv ----
// bus master end: forcing handshake, ack polling and register writes on sys_clk
`timescale 1ns/1ns
module tsw_master
  import tsw_pkg::*;
#(
  parameter int unsigned FORCE_CYCLES = FORCE_LOW_CYC
)(
  // system side
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  // command: write cmd_data to cmd_addr; force handshake first when use_force
  input  wire logic       cmd_valid,
  input  wire logic       use_force,
  input  wire logic [7:0] cmd_addr,
  input  wire logic [7:0] cmd_data,
  output logic            cmd_ready,
  output logic            done,
  output logic            fail,
  // link side
  tsw_if.master           bus
);
  typedef enum logic [6:0] {
    MS_IDLE  = 7'b0000001,
    MS_FORCE = 7'b0000010,
    MS_CHECK = 7'b0000100,
    MS_START = 7'b0001000,
    MS_BYTE  = 7'b0010000,
    MS_STOP  = 7'b0100000,
    MS_END   = 7'b1000000
  } tsw_mst_t;

  tsw_mst_t    st_r;
  logic [1:0]  scl_s_r;
  logic [1:0]  sda_s_r;
  logic [1:0]  rdy_s_r;
  logic [23:0] tmr_r;
  logic [3:0]  bit_r;
  logic [1:0]  ph_r;
  logic [1:0]  idx_r;
  logic [7:0]  addr_r;
  logic [7:0]  data_r;
  logic [3:0]  poll_r;
  logic        scl_r;
  logic        sda_r;
  logic        rdy_r;
  logic        nak_r;
  logic [7:0]  tx_byte;

  // pins pass two flops
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      scl_s_r <= 2'h3;
      sda_s_r <= 2'h3;
      rdy_s_r <= 2'h3;
    end
    else
    begin
      scl_s_r <= {scl_s_r[0], bus.scl};
      sda_s_r <= {sda_s_r[0], bus.sda};
      rdy_s_r <= {rdy_s_r[0], bus.rdy};
    end
  end

  function automatic logic [7:0] cur_byte(input logic [1:0] i, input logic [7:0] a, input logic [7:0] d);
    return (i == 2'h0) ? {DEV_ADDR, 1'b0} : ((i == 2'h1) ? a : d);
  endfunction

  // byte on the wire, held in a net because a select on a call result is not portable
  assign tx_byte = cur_byte(idx_r, addr_r, data_r);

  // sequencer; each bit is four phases, scl high phases wait for stretch
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_r   <= MS_IDLE;
      tmr_r  <= 24'h000000;
      bit_r  <= 4'h0;
      ph_r   <= 2'h0;
      idx_r  <= 2'h0;
      addr_r <= 8'h00;
      data_r <= 8'h00;
      poll_r <= 4'h0;
      scl_r  <= 1'b1;
      sda_r  <= 1'b1;
      rdy_r  <= 1'b1;
      nak_r  <= 1'b0;
      done   <= 1'b0;
      fail   <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      fail <= 1'b0;
      if (tmr_r != 24'h000000)
        tmr_r <= tmr_r - 24'h000001;
      else
        case (st_r)
          MS_IDLE:
            if (cmd_valid)
            begin
              addr_r <= cmd_addr;
              data_r <= cmd_data;
              poll_r <= 4'h0;
              if (use_force)
              begin
                rdy_r <= 1'b0;
                st_r  <= MS_FORCE;
                tmr_r <= 24'(FORCE_CYCLES);
              end
              else
                st_r <= MS_START;
            end
          MS_FORCE:
          begin
            rdy_r <= 1'b1;
            st_r  <= MS_CHECK;
            tmr_r <= 24'(2 * SCL_HALF_CYC);    // wait a bit time
          end
          MS_CHECK:
            if (!rdy_s_r[1])
              st_r <= MS_START;
            else
            begin
              rdy_r <= 1'b0;
              st_r  <= MS_FORCE;
              tmr_r <= 24'(FORCE_CYCLES);
            end
          MS_START:
          begin
            sda_r <= 1'b0;
            idx_r <= 2'h0;
            bit_r <= 4'h0;
            ph_r  <= 2'h0;
            st_r  <= MS_BYTE;
            tmr_r <= 24'(SCL_HALF_CYC);
          end
          MS_BYTE:
            case (ph_r)
              2'h0:
              begin
                scl_r <= 1'b0;
                ph_r  <= 2'h1;
                tmr_r <= 24'(SCL_HALF_CYC);
              end
              2'h1:
              begin
                sda_r <= (bit_r < 4'h8) ? tx_byte[3'(7 - bit_r)] : 1'b1;
                ph_r  <= 2'h2;
                tmr_r <= 24'(SCL_HALF_CYC);
              end
              2'h2:
              begin
                scl_r <= 1'b1;
                ph_r  <= 2'h3;
              end
              default:
                if (scl_s_r[1])                // wait out stretching
                begin
                  tmr_r <= 24'(SCL_HALF_CYC);
                  ph_r  <= 2'h0;
                  if (bit_r != 4'h8)
                    bit_r <= bit_r + 4'h1;
                  else
                  begin
                    bit_r <= 4'h0;
                    if (sda_s_r[1])
                    begin
                      nak_r <= 1'b1;
                      st_r  <= MS_STOP;
                    end
                    else if (idx_r == 2'h2)
                    begin
                      nak_r <= 1'b0;
                      st_r  <= MS_STOP;
                    end
                    else
                      idx_r <= idx_r + 2'h1;
                  end
                end
            endcase
          MS_STOP:
            case (ph_r)
              2'h0:
              begin
                scl_r <= 1'b0;
                ph_r  <= 2'h1;
                tmr_r <= 24'(SCL_HALF_CYC);
              end
              2'h1:
              begin
                sda_r <= 1'b0;
                ph_r  <= 2'h2;
                tmr_r <= 24'(SCL_HALF_CYC);
              end
              2'h2:
              begin
                scl_r <= 1'b1;
                // sda may rise only well after scl is seen high, or a stretched clock eats the stop
                if (scl_s_r[1])
                begin
                  ph_r  <= 2'h3;
                  tmr_r <= 24'(SCL_HALF_CYC);
                end
              end
              default:
              begin
                sda_r <= 1'b1;
                ph_r  <= 2'h0;
                st_r  <= MS_END;
                tmr_r <= 24'(2 * SCL_HALF_CYC);
              end
            endcase
          MS_END:
            if (nak_r && idx_r == 2'h0 && poll_r != 4'(POLL_LIMIT - 1))
            begin
              poll_r <= poll_r + 4'h1;
              st_r   <= MS_START;
            end
            else
            begin
              done <= ~nak_r;
              fail <= nak_r;
              st_r <= MS_IDLE;                 // stop after data, after an address or data nak, or after the last poll
            end
          default:
            st_r <= MS_IDLE;
        endcase
    end
  end

  assign cmd_ready    = (st_r == MS_IDLE) && (tmr_r == 24'h000000);
  assign bus.scl_o_m  = 1'b0;
  assign bus.scl_oe_m = ~scl_r;
  assign bus.sda_o_m  = 1'b0;
  assign bus.sda_oe_m = ~sda_r;
  assign bus.rdy_o_m  = 1'b0;
  assign bus.rdy_oe_m = ~rdy_r;
endmodule

// ---- tsw_link_props.sv ----
// concurrent checks on the window-ready line and the two-wire bus, link clock domain
`timescale 1ns/1ns
module tsw_link_props
#(
  parameter int unsigned STARTUP_CYCLES = 200,
  parameter int unsigned SETUP_TMO      = 400
)(
  // clock and reset
  input wire logic link_clk,
  input wire logic rst_b,
  // resolved lines
  input wire logic scl,
  input wire logic sda,
  input wire logic rdy,
  // pull-down enables of both ends
  input wire logic scl_oe_m,
  input wire logic sda_oe_m,
  input wire logic rdy_oe_m,
  input wire logic scl_oe_d,
  input wire logic sda_oe_d,
  input wire logic rdy_oe_d
);
  logic [15:0] up_cnt_r;
  int unsigned up_n;

  // link cycles since reset; saturates so a long run never wraps into the setup checks
  always_ff @(posedge link_clk or negedge rst_b)
  begin
    if (!rst_b)
      up_cnt_r <= 16'h0000;
    else if (up_cnt_r != 16'hFFFF)
      up_cnt_r <= up_cnt_r + 16'h0001;
  end
  assign up_n = {16'h0000, up_cnt_r};

  default clocking cb @(posedge link_clk); endclocking
  default disable iff (!rst_b);

  chk_ack_in_window: assert property (sda_oe_d |-> rdy_oe_d)
    else $error("device drives data outside its window");
  chk_stretch_in_window: assert property (scl_oe_d |-> rdy_oe_d)
    else $error("device holds clock outside its window");
  chk_stretch_from_low: assert property ($rose(scl_oe_d) |-> !$past(scl))
    else $error("stretch started while clock was high");
  chk_data_moves_low: assert property ($changed(sda_oe_d) |-> !scl)
    else $error("device changed data while clock high");
  chk_ack_held: assert property ($rose(sda_oe_d) |-> sda_oe_d [*8])
    else $error("acknowledge too short");
  chk_ack_ends: assert property ($rose(sda_oe_d) |-> ##[1:120] !sda_oe_d)
    else $error("acknowledge never released");
  chk_force_answer: assert property ($fell(rdy_oe_m) |-> ##[0:3] rdy_oe_d)
    else $error("forced handshake not answered");
  chk_stop_closes: assert property (scl && $past(scl) && $rose(sda) && rdy_oe_d |-> ##[1:6] !rdy_oe_d)
    else $error("stop did not close window");
  chk_setup_quiet: assert property ((up_n + 3 < STARTUP_CYCLES) |-> !rdy_oe_d)
    else $error("ready driven before setup window");
  chk_setup_open: assert property ((up_n >= STARTUP_CYCLES + 4) && (up_n + 4 <= STARTUP_CYCLES + SETUP_TMO)
    |-> rdy_oe_d)
    else $error("setup window not held open");
  chk_setup_tmo: assert property ((up_n == STARTUP_CYCLES + SETUP_TMO + 6) |-> !rdy_oe_d)
    else $error("setup window did not time out");

  // main scenarios reached
  cov_forced: cover property (rdy_oe_m && $rose(rdy_oe_d));
  cov_ack: cover property ($rose(sda_oe_d));
  cov_stretch: cover property ($rose(scl_oe_d));
  cov_stop_close: cover property (scl && $rose(sda) && rdy_oe_d);
endmodule

// ---- touch_sensor_i2c_comms_window_tb_top.sv ----
// self-checking bench: master and device ends joined by the link interface
`timescale 1ns/1ns
module touch_sensor_i2c_comms_window_tb_top
  import tsw_pkg::*;
;
  // short counts so the run stays brief; expectations follow them
  localparam int unsigned STUP = 200;
  localparam int unsigned TMO  = 400;
  localparam int unsigned FRC  = 3000;
  localparam int unsigned TLIM = 90000;
  typedef struct packed {logic [1:0] k; logic [7:0] a; logic [7:0] d;} tsw_exp_t;

  logic       sys_clk, link_clk, rst_b;
  logic       cmd_valid, use_force, cmd_ready, done, fail;
  logic [7:0] cmd_addr, cmd_data, wr_addr, wr_data;
  logic       conv_done, stretch_req, conv_start, wr_stb, in_window, stretch_en;
  int         num_errors, num_checks, resp_n, start_n, cyc_n;
  tsw_exp_t   exp_q[$];
  logic [7:0] addrs [7] = '{8'h00, 8'h3F, 8'h40, 8'h7F, 8'h80, 8'h9F, 8'hA0};

  always #25 sys_clk = ~sys_clk;
  // link clock of 125 ns with its own phase
  always
  begin
    #62 link_clk = ~link_clk;
    #63 link_clk = ~link_clk;
  end

  tsw_if tsw_if_inst ();
  tsw_device #(.STARTUP_CYCLES(STUP), .SETUP_TMO(TMO)) tsw_device_inst (
    .link_clk(link_clk), .rst_b(rst_b), .bus(tsw_if_inst.device), .conv_done(conv_done),
    .stretch_req(stretch_req), .conv_start(conv_start), .wr_stb(wr_stb), .wr_addr(wr_addr),
    .wr_data(wr_data), .in_window(in_window));
  tsw_master #(.FORCE_CYCLES(FRC)) tsw_master_inst (
    .sys_clk(sys_clk), .rst_b(rst_b), .cmd_valid(cmd_valid), .use_force(use_force), .cmd_addr(cmd_addr),
    .cmd_data(cmd_data), .cmd_ready(cmd_ready), .done(done), .fail(fail), .bus(tsw_if_inst.master));
  tsw_link_props #(.STARTUP_CYCLES(STUP), .SETUP_TMO(TMO)) tsw_link_props_inst (
    .link_clk(link_clk), .rst_b(rst_b), .scl(tsw_if_inst.scl), .sda(tsw_if_inst.sda), .rdy(tsw_if_inst.rdy),
    .scl_oe_m(tsw_if_inst.scl_oe_m), .sda_oe_m(tsw_if_inst.sda_oe_m), .rdy_oe_m(tsw_if_inst.rdy_oe_m),
    .scl_oe_d(tsw_if_inst.scl_oe_d), .sda_oe_d(tsw_if_inst.sda_oe_d), .rdy_oe_d(tsw_if_inst.rdy_oe_d));

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic c, input string m);
    num_checks++;
    if (c !== 1'b1)
    begin
      num_errors++;
      $display("MISMATCH t=%0t %s", $time, m);
    end
  endtask

  // oldest note against the result just seen: 0 write, 1 done, 2 fail
  task automatic take(input logic [1:0] k, input logic [7:0] a, input logic [7:0] d);
    tsw_exp_t e;
    if (exp_q.size() == 0)
      chk(1'b0, "result with no expectation");
    else
    begin
      e = exp_q.pop_front();
      chk(e.k === k && (k != 2'h0 || (e.a === a && e.d === d)), "result differs");
    end
  endtask

  // one write command; unmapped targets are acked but must not reach the engine
  task automatic do_cmd(input logic f, input logic [7:0] a, input logic ok);
    logic [7:0] d;
    logic       r;
    int         n;
    d = 8'($urandom());
    if (ok && (a <= MAP_LTA_LAST || (a >= MAP_SET_FIRST && a <= MAP_SET_LAST)))
      exp_q.push_back('{2'h0, a, d});
    exp_q.push_back('{(ok ? 2'h1 : 2'h2), 8'h00, 8'h00});
    n = resp_n;
    @(posedge sys_clk);
    #2;
    cmd_valid = 1'b1;
    use_force = f;
    cmd_addr = a;
    cmd_data = d;
    r = 1'b0;
    while (r !== 1'b1)
    begin
      r = cmd_ready;
      @(posedge sys_clk);
    end
    #2;
    cmd_valid = 1'b0;
    while (resp_n == n && cyc_n < TLIM)
      @(posedge sys_clk);
  endtask

  // conversion finished: window must open with ready held low
  task automatic open_win();
    int n;
    @(posedge link_clk);
    #2;
    conv_done = 1'b1;
    @(posedge link_clk);
    #2;
    conv_done = 1'b0;
    n = 0;
    while (in_window !== 1'b1 && n < 50)
    begin
      @(negedge link_clk);
      n++;
    end
    chk(tsw_if_inst.rdy === 1'b0, "ready not low in window");
  endtask

  // engine-side results are sampled mid-cycle, away from the launching edge
  always @(negedge link_clk)
  begin
    if (wr_stb === 1'b1)
      take(2'h0, wr_addr, wr_data);
    if (conv_start === 1'b1)
      start_n++;
  end

  // command results and the hang limit
  always @(negedge sys_clk)
  begin
    cyc_n++;
    if (done === 1'b1 || fail === 1'b1)
    begin
      take((done === 1'b1) ? 2'h1 : 2'h2, 8'h00, 8'h00);
      resp_n++;
    end
    if (cyc_n == TLIM)
    begin
      num_errors++;
      $display("MISMATCH t=%0t run did not finish", $time);
      give_verdict();
    end
  end

  // random stretch requests while enabled
  always @(posedge link_clk)
  begin
    #2;
    stretch_req = stretch_en & (($urandom() % 4) == 0);
  end

  initial
  begin
    int n;
    int s;
    sys_clk = 1'b0;
    link_clk = 1'b0;
    rst_b = 1'b0;
    cmd_valid = 1'b0;
    use_force = 1'b0;
    cmd_addr = 8'h00;
    cmd_data = 8'h00;
    conv_done = 1'b0;
    stretch_en = 1'b0;
    stretch_req = 1'b0;
    void'($urandom(86380));
    repeat (4) @(posedge sys_clk);
    #2;
    rst_b = 1'b1;
    // setup window opens by itself, then times out unserviced
    n = 0;
    while (in_window !== 1'b1 && n < 1000)
    begin
      @(negedge link_clk);
      n++;
    end
    chk(n + 2 >= STUP && n <= STUP + 4, "setup window open time");
    chk(tsw_if_inst.rdy === 1'b0, "ready not low in setup window");
    n = 0;
    while (in_window === 1'b1 && n < 1000)
    begin
      @(negedge link_clk);
      n++;
    end
    chk(n + 4 >= TMO && n <= TMO + 4, "setup window timeout");
    chk(tsw_if_inst.rdy === 1'b1, "ready not released after timeout");
    $display("test setup_window finished");
    // polling during a conversion gets no acknowledge and changes nothing
    do_cmd(1'b0, 8'h10, 1'b0);
    chk(in_window === 1'b0 && start_n == 0, "polling changed state");
    $display("test polling finished");
    // map edges, the gap and beyond, each in a fresh window closed by stop
    foreach (addrs[i])
    begin
      s = start_n;
      open_win();
      do_cmd(1'b0, addrs[i], 1'b1);
      chk(start_n == s + 1 && in_window === 1'b0, "stop did not close window");
    end
    $display("test map_writes finished");
    // window forced from conversion by the master
    do_cmd(1'b1, MAP_SET_FIRST + 8'($urandom_range(0, 31)), 1'b1);
    $display("test forced_window finished");
    // write with the device stretching the clock at random
    stretch_en = 1'b1;
    open_win();
    do_cmd(1'b0, 8'h85, 1'b1);
    stretch_en = 1'b0;
    repeat (10) @(posedge sys_clk);
    chk(exp_q.size() == 0, "expected results missing");
    $display("test stretch finished");
    give_verdict();
  end
endmodule
